// >>> rtl/ptcb_regs.svh
// register offsets, reset values and field positions for the pwm timebase block
`ifndef PTCB_REGS_SVH
`define PTCB_REGS_SVH
// Summary of operation
// - 16-bit period register resets to 0xfff8: bits 15..3 one, 2..0 zero.
// - 16-bit special event compare register, reset zero, writable.
// - chop selector: 0 internal chop clock, 1..3 generator high outputs.
// - high chop enable bit 1, low chop enable bit 0, both reset zero.
// - aux control bits 15..12 and 7..6 ignore writes, read zero.
`define PTCB_OFF_PERIOD   4'h0
`define PTCB_OFF_COMPARE  4'h4
`define PTCB_OFF_AUX      4'h8
`define PTCB_OFF_TIMER    4'hc
`define PTCB_RST_PERIOD   16'hfff8
`define PTCB_RST_COMPARE  16'h0000
`define PTCB_RST_AUX      16'h0000
`define PTCB_AUX_MASK     16'h0f3f
`define PTCB_BLANK_LSB    8
`define PTCB_CHOP_LSB     2
`define PTCB_HEN_BIT      1
`define PTCB_LEN_BIT      0
`endif

// >>> rtl/ptcb_pkg.sv
// types shared by the pwm timebase block
package ptcb_pkg;
	typedef struct packed {
		logic [3:0] blank_source_select;
		logic [3:0] chop_source_select;
		logic       high_chop_enable;
		logic       low_chop_enable;
	} ptcb_aux_type;
	typedef enum logic [1:0] {
		PTCB_W_IDLE = 2'b00,
		PTCB_W_RESP = 2'b01
	} ptcb_wstate_type;
endpackage

// >>> rtl/ptcb_top.sv
// pwm master time base, special event, blanking and chop control
`timescale 1ns/100ps
`default_nettype none
`include "ptcb_regs.svh"
module ptcb_top
	import ptcb_pkg::*;
(
	input  wire logic        mclk,
	input  wire logic        rst,
	input  wire logic [3:0]  s_awaddr,
	input  wire logic        s_awvalid,
	output var  logic        s_awready,
	input  wire logic [31:0] s_wdata,
	input  wire logic [3:0]  s_wstrb,
	input  wire logic        s_wvalid,
	output var  logic        s_wready,
	output var  logic [1:0]  s_bresp,
	output var  logic        s_bvalid,
	input  wire logic        s_bready,
	input  wire logic [3:0]  s_araddr,
	input  wire logic        s_arvalid,
	output var  logic        s_arready,
	output var  logic [31:0] s_rdata,
	output var  logic [1:0]  s_rresp,
	output var  logic        s_rvalid,
	input  wire logic        s_rready,
	input  wire logic [2:0]  gen_high_in,
	input  wire logic        gen_high_out_raw,
	input  wire logic        gen_low_out_raw,
	input  wire logic        chop_clock,
	input  wire logic        current_limit_in,
	input  wire logic        fault_in,
	output var  logic        gen_high_out,
	output var  logic        gen_low_out,
	output var  logic        current_limit_masked,
	output var  logic        fault_masked,
	output var  logic        special_event
);
	// ------------------------------------------------
	// pin synchronisers
	// ------------------------------------------------
	logic [5:0] sync1;
	logic [5:0] sync2;
	// cleared in reset so the masks see idle pins, not unknowns, at release
	always_ff @(posedge mclk) begin
		if (rst) begin
			sync1 <= 6'h00;
			sync2 <= 6'h00;
		end else begin
			sync1 <= {fault_in, current_limit_in, chop_clock, gen_high_in};
			sync2 <= sync1;
		end
	end
	wire logic [2:0] hi_s   = sync2[2:0];
	wire logic       chop_s = sync2[3];
	wire logic       lim_s  = sync2[4];
	wire logic       flt_s  = sync2[5];

	// ------------------------------------------------
	// registers
	// ------------------------------------------------
	logic [15:0]  master_period;
	logic [15:0]  special_event_compare;
	ptcb_aux_type aux_blank_chop_control;
	logic [15:0]  primary_master_timer;

	function automatic logic pick_source(input logic [3:0] sel,
		input logic zero_src, input logic [2:0] hi);
		case (sel)
			4'h0:    pick_source = zero_src;
			4'h1:    pick_source = hi[0];
			4'h2:    pick_source = hi[1];
			4'h3:    pick_source = hi[2];
			default: pick_source = 1'b0;
		endcase
	endfunction

	// ------------------------------------------------
	// axi4-lite write side
	// ------------------------------------------------
	logic [3:0]  aw_addr;
	logic        aw_have;
	logic [15:0] w_data;
	logic [1:0]  w_strb;
	logic        w_have;
	wire logic   do_write = aw_have && w_have && !s_bvalid;
	wire logic [15:0] wmask = {{8{w_strb[1]}}, {8{w_strb[0]}}};
	wire logic   w_ok = (aw_addr == `PTCB_OFF_PERIOD) ||
		(aw_addr == `PTCB_OFF_COMPARE) || (aw_addr == `PTCB_OFF_AUX) ||
		(aw_addr == `PTCB_OFF_TIMER);
	wire logic [15:0] aux_word = {4'h0, aux_blank_chop_control.blank_source_select,
		2'b00, aux_blank_chop_control.chop_source_select,
		aux_blank_chop_control.high_chop_enable,
		aux_blank_chop_control.low_chop_enable};
	// unimplemented aux bits dropped on write
	wire logic [15:0] next_aux = ((aux_word & ~wmask) | (w_data & wmask))
		& `PTCB_AUX_MASK;

	always_ff @(posedge mclk) begin
		if (rst) begin
			aw_have   <= 1'b0;
			w_have    <= 1'b0;
			aw_addr   <= 4'h0;
			w_data    <= 16'h0000;
			w_strb    <= 2'b00;
			s_awready <= 1'b0;
			s_wready  <= 1'b0;
			s_bvalid  <= 1'b0;
			s_bresp   <= 2'b00;
		end else begin
			s_awready <= !aw_have && !(s_awvalid && s_awready);
			s_wready  <= !w_have && !(s_wvalid && s_wready);
			if (s_awvalid && s_awready) begin
				aw_have <= 1'b1;
				aw_addr <= s_awaddr;
			end
			if (s_wvalid && s_wready) begin
				w_have <= 1'b1;
				w_data <= s_wdata[15:0];
				w_strb <= s_wstrb[1:0];
			end
			if (do_write) begin
				aw_have   <= 1'b0;
				w_have    <= 1'b0;
				s_bvalid  <= 1'b1;
				s_bresp   <= w_ok ? 2'b00 : 2'b10;
				s_awready <= 1'b0;
				s_wready  <= 1'b0;
			end
			if (s_bvalid && s_bready) begin
				s_bvalid <= 1'b0;
			end
		end
	end

	always_ff @(posedge mclk) begin
		if (rst) begin
			master_period         <= `PTCB_RST_PERIOD;
			special_event_compare <= `PTCB_RST_COMPARE;
			aux_blank_chop_control <= '0;
		end else if (do_write) begin
			if (aw_addr == `PTCB_OFF_PERIOD) begin
				master_period <= (master_period & ~wmask) | (w_data & wmask);
			end
			if (aw_addr == `PTCB_OFF_COMPARE) begin
				special_event_compare <= (special_event_compare & ~wmask)
					| (w_data & wmask);
			end
			if (aw_addr == `PTCB_OFF_AUX) begin
				aux_blank_chop_control <= {next_aux[11:8], next_aux[5:2],
					next_aux[`PTCB_HEN_BIT], next_aux[`PTCB_LEN_BIT]};
			end
		end
	end

	// ------------------------------------------------
	// axi4-lite read side
	// ------------------------------------------------
	logic [15:0] rd_word;
	logic        rd_ok;
	always_comb begin
		rd_ok = 1'b1;
		case (s_araddr)
			`PTCB_OFF_PERIOD:  rd_word = master_period;
			`PTCB_OFF_COMPARE: rd_word = special_event_compare;
			`PTCB_OFF_AUX:     rd_word = aux_word;
			`PTCB_OFF_TIMER:   rd_word = primary_master_timer;
			default: begin
				rd_word = 16'h0000;
				rd_ok   = 1'b0;
			end
		endcase
	end

	always_ff @(posedge mclk) begin
		if (rst) begin
			s_arready <= 1'b0;
			s_rvalid  <= 1'b0;
			s_rdata   <= 32'h0000_0000;
			s_rresp   <= 2'b00;
		end else begin
			s_arready <= !s_rvalid && !(s_arvalid && s_arready);
			if (s_arvalid && s_arready) begin
				s_rvalid  <= 1'b1;
				s_rdata   <= {16'h0000, rd_word};
				s_rresp   <= rd_ok ? 2'b00 : 2'b10;
				s_arready <= 1'b0;
			end else if (s_rvalid && s_rready) begin
				s_rvalid <= 1'b0;
			end
		end
	end

	// ------------------------------------------------
	// master time base
	// ------------------------------------------------
	// wrap at period
	wire logic at_period = (primary_master_timer >= master_period);
	wire logic [15:0] next_timer = at_period ? 16'h0000
		: primary_master_timer + 16'h0001;
	always_ff @(posedge mclk) begin
		if (rst) begin
			primary_master_timer <= 16'h0000;
			special_event        <= 1'b0;
		end else begin
			primary_master_timer <= next_timer;
			special_event <= (next_timer == special_event_compare);
		end
	end

	// ------------------------------------------------
	// blanking and chopping
	// ------------------------------------------------
	// blank source pick
	wire logic blank_sig = pick_source(aux_blank_chop_control.blank_source_select,
		1'b0, hi_s);
	wire logic chop_sig = pick_source(aux_blank_chop_control.chop_source_select,
		chop_s, hi_s);
	// raw outputs come from same-clock logic, so no sync needed
	always_ff @(posedge mclk) begin
		if (rst) begin
			gen_high_out         <= 1'b0;
			gen_low_out          <= 1'b0;
			current_limit_masked <= 1'b0;
			fault_masked         <= 1'b0;
		end else begin
			gen_high_out <= gen_high_out_raw &&
				(!aux_blank_chop_control.high_chop_enable || chop_sig);
			gen_low_out  <= gen_low_out_raw &&
				(!aux_blank_chop_control.low_chop_enable || chop_sig);
			current_limit_masked <= lim_s && !blank_sig;
			fault_masked         <= flt_s && !blank_sig;
		end
	end

	// ------------------------------------------------
	// assertions
	// ------------------------------------------------
	period_wrap_a: assert property (@(posedge mclk) disable iff (rst)
		(primary_master_timer >= master_period) |=> primary_master_timer == 16'h0000)
		else $error("timer did not wrap at period");
	event_match_a: assert property (@(posedge mclk) disable iff (rst)
		special_event
		|-> primary_master_timer == $past(special_event_compare))
		else $error("special event without compare match");
	aux_zero_a: assert property (@(posedge mclk) disable iff (rst)
		(aux_word & ~`PTCB_AUX_MASK) == 16'h0000)
		else $error("unimplemented aux bits set");
	period_reset_a: assert property (@(posedge mclk)
		$past(rst) |-> master_period == 16'hfff8)
		else $error("period reset value wrong");
	compare_reset_a: assert property (@(posedge mclk)
		$past(rst) |-> special_event_compare == 16'h0000)
		else $error("compare reset value wrong");
	chop_off_a: assert property (@(posedge mclk) disable iff (rst)
		!aux_blank_chop_control.high_chop_enable |=> gen_high_out == $past(gen_high_out_raw))
		else $error("high output chopped while disabled");
	no_blank_a: assert property (@(posedge mclk) disable iff (rst)
		aux_blank_chop_control.blank_source_select == 4'h0 |=> fault_masked == $past(flt_s))
		else $error("fault masked with no blank source");
	chop_int_a: assert property (@(posedge mclk) disable iff (rst)
		(aux_blank_chop_control.chop_source_select == 4'h0 &&
		aux_blank_chop_control.low_chop_enable && !chop_s)
		|=> !gen_low_out)
		else $error("low output not chopped by internal clock");
	hi_chop_a: assert property (@(posedge mclk) disable iff (rst)
		(aux_blank_chop_control.chop_source_select == 4'h0 &&
		aux_blank_chop_control.high_chop_enable && !chop_s)
		|=> !gen_high_out)
		else $error("high output not chopped by internal clock");
	lo_pass_a: assert property (@(posedge mclk) disable iff (rst)
		!aux_blank_chop_control.low_chop_enable
		|=> gen_low_out == $past(gen_low_out_raw))
		else $error("low output chopped while disabled");
	limit_open_a: assert property (@(posedge mclk) disable iff (rst)
		aux_blank_chop_control.blank_source_select == 4'h0
		|=> current_limit_masked == $past(lim_s))
		else $error("limit masked with no blank source");
	blank_mask_a: assert property (@(posedge mclk) disable iff (rst)
		((aux_blank_chop_control.blank_source_select == 4'h1 && hi_s[0]) ||
		(aux_blank_chop_control.blank_source_select == 4'h2 && hi_s[1]) ||
		(aux_blank_chop_control.blank_source_select == 4'h3 && hi_s[2]))
		|=> !current_limit_masked && !fault_masked)
		else $error("inputs not masked by blank source");
	timer_step_a: assert property (@(posedge mclk) disable iff (rst)
		(!rst && primary_master_timer < master_period)
		|=> primary_master_timer == $past(primary_master_timer) + 16'h0001)
		else $error("timer did not count up");
	aux_read_a: assert property (@(posedge mclk) disable iff (rst)
		(s_arvalid && s_arready && s_araddr == `PTCB_OFF_AUX)
		|=> s_rdata[15:12] == 4'h0 && s_rdata[7:6] == 2'b00)
		else $error("unimplemented aux bits read nonzero");
	period_wr_a: assert property (@(posedge mclk) disable iff (rst)
		(do_write && aw_addr == `PTCB_OFF_PERIOD && w_strb == 2'b11)
		|=> master_period == $past(w_data))
		else $error("period write lost");
	compare_wr_a: assert property (@(posedge mclk) disable iff (rst)
		(do_write && aw_addr == `PTCB_OFF_COMPARE && w_strb == 2'b11)
		|=> special_event_compare == $past(w_data))
		else $error("compare write lost");
endmodule
`default_nettype wire

// >>> test/ptcb_stage.sv
// power stage side model: pin levels that the bench asks for
`timescale 1ns/100ps
`default_nettype none
module ptcb_stage (
	input  wire logic       mclk,
	input  wire logic [7:0] want,
	output var  logic [2:0] gen_high_in,
	output var  logic       gen_high_out_raw,
	output var  logic       gen_low_out_raw,
	output var  logic       chop_clock,
	output var  logic       current_limit_in,
	output var  logic       fault_in
);
	// levels move only just after an edge, as a real driver stage would
	always @(posedge mclk) begin
		{fault_in, current_limit_in, chop_clock, gen_low_out_raw,
			gen_high_out_raw, gen_high_in} <= want;
	end
endmodule
`default_nettype wire

// >>> test/testbench.sv
// self-checking bench for the pwm timebase block
`timescale 1ns/100ps
`default_nettype none
`include "ptcb_regs.svh"
module testbench
	import ptcb_pkg::*;
;
	logic        mclk, rst, s_awvalid, s_wvalid, s_bready, s_arvalid;
	logic        s_rready, s_awready, s_wready, s_bvalid, s_arready;
	logic        s_rvalid, gen_high_out_raw, gen_low_out_raw, chop_clock;
	logic        current_limit_in, fault_in, gen_high_out, gen_low_out;
	logic        current_limit_masked, fault_masked, special_event;
	logic [3:0]  s_awaddr, s_araddr, s_wstrb;
	logic [1:0]  s_bresp, s_rresp;
	logic [31:0] s_wdata, s_rdata;
	logic [2:0]  gen_high_in;
	logic [7:0]  want;
	int          err_total, num_checks;

	ptcb_top dut_u (.mclk, .rst, .s_awaddr, .s_awvalid, .s_awready,
		.s_wdata, .s_wstrb, .s_wvalid, .s_wready, .s_bresp, .s_bvalid,
		.s_bready, .s_araddr, .s_arvalid, .s_arready, .s_rdata, .s_rresp,
		.s_rvalid, .s_rready, .gen_high_in, .gen_high_out_raw,
		.gen_low_out_raw, .chop_clock, .current_limit_in, .fault_in,
		.gen_high_out, .gen_low_out, .current_limit_masked, .fault_masked,
		.special_event);
	ptcb_stage stage_u (.mclk, .want, .gen_high_in, .gen_high_out_raw,
		.gen_low_out_raw, .chop_clock, .current_limit_in, .fault_in);

	always #20 mclk = ~mclk;

	// ----
	// shared tasks
	// ----
	task end_of_test;
		$display("checks %0d errors %0d", num_checks, err_total);
		if (err_total == 0 && num_checks > 0)
			$display("SIMULATION PASSED");
		else
			$display("SIMULATION FAILED");
		$finish;
	endtask
	task chk(input string nm, input logic [31:0] e, input logic [31:0] g);
		num_checks++;
		if (g !== e) begin
			$display("BAD %s expected %h seen %h", nm, e, g);
			err_total++;
		end
	endtask
	task wr(input logic [3:0] a, input logic [15:0] d, input logic [1:0] r);
		int n;
		@(posedge mclk);
		s_awaddr <= a;
		s_wdata <= {16'h0000, d};
		s_awvalid <= 1'b1;
		s_wvalid <= 1'b1;
		s_bready <= 1'b1;
		for (n = 0; n < 40; n++) begin
			@(posedge mclk);
			if (s_awready) s_awvalid <= 1'b0;
			if (s_wready) s_wvalid <= 1'b0;
			if (s_bvalid) break;
		end
		s_bready <= 1'b0;
		if (n == 40) begin
			err_total++;
			end_of_test;
		end
		chk("bresp", {30'h0, r}, {30'h0, s_bresp});
	endtask
	task rd(input logic [3:0] a, input logic [15:0] e, input logic [1:0] r);
		int n;
		@(posedge mclk);
		s_araddr <= a;
		s_arvalid <= 1'b1;
		s_rready <= 1'b1;
		for (n = 0; n < 40; n++) begin
			@(posedge mclk);
			if (s_arready) s_arvalid <= 1'b0;
			if (s_rvalid) break;
		end
		s_rready <= 1'b0;
		if (n == 40) begin
			err_total++;
			end_of_test;
		end
		chk("rdata", {16'h0000, e}, s_rdata);
		chk("rresp", {30'h0, r}, {30'h0, s_rresp});
	endtask
	// e is {high out, low out, limit masked, fault masked}
	task pins(input logic [15:0] aux, input logic [7:0] p, input logic [3:0] e);
		wr(`PTCB_OFF_AUX, aux, 2'b00);
		want <= p;
		repeat (6) @(posedge mclk);
		chk("pins", {28'h0, e}, {28'h0, gen_high_out, gen_low_out,
			current_limit_masked, fault_masked});
	endtask

	// ----
	// scenarios
	// ----
	task scen_reset;
		rd(`PTCB_OFF_PERIOD, 16'hfff8, 2'b00);
		rd(`PTCB_OFF_COMPARE, 16'h0000, 2'b00);
		rd(`PTCB_OFF_AUX, 16'h0000, 2'b00);
	endtask
	task scen_regs;
		wr(`PTCB_OFF_PERIOD, 16'h1234, 2'b00);
		rd(`PTCB_OFF_PERIOD, 16'h1234, 2'b00);
		s_wstrb <= 4'h1;
		wr(`PTCB_OFF_PERIOD, 16'habff, 2'b00);
		s_wstrb <= 4'hf;
		rd(`PTCB_OFF_PERIOD, 16'h12ff, 2'b00);
		wr(`PTCB_OFF_COMPARE, 16'habcd, 2'b00);
		rd(`PTCB_OFF_COMPARE, 16'habcd, 2'b00);
		wr(`PTCB_OFF_AUX, 16'hffff, 2'b00);
		rd(`PTCB_OFF_AUX, 16'h0f3f, 2'b00);
		wr(4'h2, 16'h5555, 2'b10);
		rd(4'h2, 16'h0000, 2'b10);
	endtask
	task scen_timebase;
		int n;
		wr(`PTCB_OFF_PERIOD, 16'h0009, 2'b00);
		wr(`PTCB_OFF_COMPARE, 16'h0004, 2'b00);
		for (n = 0; n < 100 && !special_event; n++) @(posedge mclk);
		chk("event_first", 32'd1, {31'h0, special_event});
		for (n = 1; n < 100; n++) begin
			@(posedge mclk);
			if (special_event) break;
		end
		chk("event_gap", 32'd10, n);
	endtask
	task scen_chop;
		int k;
		logic [7:0] b;
		pins(16'h0003, 8'h18, 4'b0000);
		pins(16'h0003, 8'h38, 4'b1100);
		pins(16'h0000, 8'h18, 4'b1100);
		pins(16'h0002, 8'h18, 4'b0100);
		pins(16'h0013, 8'h3f, 4'b0000);
		for (k = 1; k < 4; k++) begin
			b = 8'(1 << (k - 1));
			pins(16'(4 * k + 3), 8'h18 | b, 4'b1100);
			pins(16'(4 * k + 3), 8'h18 | (b ^ 8'h07), 4'b0000);
		end
	endtask
	task scen_blank;
		int k;
		logic [7:0] b;
		pins(16'h0000, 8'hc7, 4'b0011);
		pins(16'h0400, 8'hc7, 4'b0011);
		for (k = 1; k < 4; k++) begin
			b = 8'(1 << (k - 1));
			pins(16'(256 * k), 8'hc0 | b, 4'b0000);
			pins(16'(256 * k), 8'hc0 | (b ^ 8'h07), 4'b0011);
		end
	endtask

	initial begin
		mclk = 1'b0;
		rst = 1'b1;
		{s_awvalid, s_wvalid, s_bready, s_arvalid, s_rready} = 5'h00;
		{s_awaddr, s_araddr} = 8'h00;
		s_wstrb = 4'hf;
		s_wdata = 32'h0;
		want = 8'h00;
		err_total = 0;
		num_checks = 0;
		repeat (2) @(posedge mclk);
		rst <= 1'b0;
		repeat (2) @(posedge mclk);
		scen_reset;
		scen_regs;
		scen_timebase;
		scen_chop;
		scen_blank;
		end_of_test;
	end
endmodule
`default_nettype wire
